// ---- apr_core.sv ----
// Purpose: Analog preset and mask/unmask receive data direct commands.
// Assumes: Register port and command strobe decoded from the serial port.
// Notes: Commands complete in one cycle and never raise an interrupt.
// Function
// [RQ1] Analog preset rewrites listed TX/RX bits from mode and bit rate.
// [RQ2] Host avoids analog preset in subcarrier or BPSK stream modes.
// [RQ3] Preset sets receive channel count bit for NFC active modes.
// [RQ4] Preset clears transmitter enable in NFC initiator and target modes.
// [RQ5] Preset sets start and length byte insertion for NFC active.
// [RQ6] Preset picks OOK or AM transmit modulation from mode and rate.
// [RQ7] Preset enables peer field detector only for NFC active.
// [RQ8] Preset selects AM demodulation channel for NFC active.
// [RQ9] Preset selects peak detector up to 848 kb/s, mixer above.
// [RQ10] Preset loads low-pass and zero-setting bits by mode and rate.
// [RQ11] Preset sets stage output clipping only for NFC active.
// [RQ12] Preset sets forced gain reduction only for NFC active.
// [RQ13] Mask command drops receiver activity and stops receive framing.
// [RQ14] Effective mask is command mask OR mask timer.
// [RQ15] Unmask command raises receiver activity and enables framing.
// [RQ16] Unmask while mask timer runs enables reception and resets timer.
// [RQ17] Mask and unmask are ignored while receiver enable is clear.
// [RQ18] Mask and unmask allow chaining and raise no interrupt.
// [RQ19] Preset leaves other bits unchanged and raises no interrupt.
`timescale 1ns/1ps
`default_nettype none
module apr_core (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register access.
    input wire apr_pkg::apr_reg_req_t regReq,
    output logic [7:0] regRdata,
    output logic regRdValid,
    // Direct commands.
    input wire apr_pkg::apr_cmd_t cmd,
    output logic cmdDone,
    output logic cmdIgnored,
    // Receiver control.
    output apr_pkg::apr_rx_ctrl_t rxCtrl,
    // Configuration bits toward the analog front end.
    output logic [7:0] opctlOut,
    output logic [7:0] typeAOut,
    output logic [7:0] auxOut,
    output logic [7:0] rxCfg1Out,
    output logic [7:0] rxCfg3Out
);
    import apr_pkg::*;

    apr_core_state_t s;
    apr_core_state_t next_s;
    logic timerStart;
    logic timerClear;
    logic timerRunning;
    logic rxEnBit;
    logic nfcAct;
    logic [3:0] mode;
    logic [3:0] rxRate;
    logic [3:0] txRate;
    logic presetGo;
    logic maskGo;
    logic unmaskGo;
    logic rxActive;

    function automatic logic [7:0] regRead(input apr_core_state_t st,
                                           input logic [5:0] a);
        unique case (a)
            ADDR_OPCTL: return st.opctl;
            ADDR_MODE: return st.modeDef;
            ADDR_RATE: return st.rateDef;
            ADDR_TYPEA: return st.typeA;
            ADDR_AUX: return st.aux;
            ADDR_RXCFG1: return st.rxCfg1;
            ADDR_RXCFG3: return st.rxCfg3;
            ADDR_MASK_PERIOD: return st.maskPeriod;
            default: return RDATA_UNMAPPED;
        endcase
    endfunction : regRead

    assign rxEnBit = s.opctl[OPC_RXEN];
    assign mode = s.modeDef[MODE_LSB +: 4];
    assign rxRate = s.rateDef[RATE_RX_LSB +: 4];
    assign txRate = s.rateDef[RATE_TX_LSB +: 4];
    assign nfcAct = isNfcActive(mode);
    assign presetGo = cmd.valid && (cmd.code == CMD_ANALOG_PRESET);
    assign maskGo = cmd.valid && (cmd.code == CMD_MASK_RX);
    assign unmaskGo = cmd.valid && (cmd.code == CMD_UNMASK_RX);

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.ignored = 1'b0;
        next_s.rdValid = regReq.re;
        timerStart = 1'b0;
        timerClear = 1'b0;
        if (regReq.re) begin
            next_s.rdata = regRead(s, regReq.addr);
        end
        if (regReq.we) begin
            unique case (regReq.addr)
                ADDR_OPCTL: next_s.opctl = regReq.wdata;
                ADDR_MODE: next_s.modeDef = regReq.wdata;
                ADDR_RATE: next_s.rateDef = regReq.wdata;
                ADDR_TYPEA: next_s.typeA = regReq.wdata;
                ADDR_AUX: next_s.aux = regReq.wdata;
                ADDR_RXCFG1: next_s.rxCfg1 = regReq.wdata;
                ADDR_RXCFG3: next_s.rxCfg3 = regReq.wdata;
                ADDR_MASK_PERIOD: next_s.maskPeriod = regReq.wdata;
                default: begin
                end
            endcase
        end
        if (presetGo) begin // RQ19
            // Only the listed bits move; all others keep their value.
            next_s.opctl[OPC_RXCHN] = nfcAct; // RQ1 RQ3
            if (nfcAct) begin
                next_s.opctl[OPC_TXEN] = 1'b0; // RQ4
                next_s.rxCfg1[RX1_DEMOD_CHANNEL_SELECT] = 1'b0; // RQ8
            end
            next_s.typeA[TA_START_AND_LENGTH_BYTE_INSERT] = nfcAct; // RQ5
            if (mode == MODE_ISO_A) begin
                next_s.aux[AUX_TRANSMIT_MODULATION_TYPE] = 1'b0; // RQ6
            end else if (mode == MODE_ISO_B || mode == MODE_CARD_212_424) begin
                next_s.aux[AUX_TRANSMIT_MODULATION_TYPE] = 1'b1; // RQ6
            end else if (nfcAct) begin
                next_s.aux[AUX_TRANSMIT_MODULATION_TYPE] =
                    (txRate != RATE_106); // RQ6
            end
            next_s.aux[AUX_PEER_FIELD_DETECT_ENABLE] = nfcAct; // RQ7
            next_s.rxCfg1[RX1_DEMOD_TYPE] = (rxRate > RATE_848); // RQ9
            next_s.rxCfg1[RX1_FILTER_LSB +: 6] =
                filterFor(mode, rxRate); // RQ10
            next_s.rxCfg3[RX3_CLIP] = nfcAct; // RQ11
            next_s.rxCfg3[RX3_FORCED_GAIN_REDUCTION] = nfcAct; // RQ12
            next_s.done = 1'b1;
        end else if (maskGo || unmaskGo) begin
            if (rxEnBit) begin
                next_s.cmdMask = maskGo; // RQ13 RQ15
                timerClear = unmaskGo; // RQ16
                next_s.done = 1'b1; // RQ18
            end else begin
                next_s.ignored = 1'b1; // RQ17
            end
        end else if (cmd.valid && cmd.code == CMD_START_MASK_TIMER) begin
            if (rxEnBit) begin
                timerStart = 1'b1;
                next_s.done = 1'b1;
            end else begin
                next_s.ignored = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{opctl: RST_OPCTL, modeDef: RST_MODE, rateDef: RST_RATE,
                   typeA: RST_TYPEA, aux: RST_AUX, rxCfg1: RST_RXCFG1,
                   rxCfg3: RST_RXCFG3, maskPeriod: RST_MASK_PERIOD,
                   cmdMask: 1'b0, rdata: RDATA_UNMAPPED, rdValid: 1'b0,
                   done: 1'b0, ignored: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    apr_mask_timer u_mask_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(timerStart),
        .clear(timerClear),
        .period(s.maskPeriod),
        .running(timerRunning)
    );

    // Reception is masked by either the command or the timer.
    assign rxActive = rxEnBit && !(s.cmdMask || timerRunning); // RQ14
    assign rxCtrl = '{rxOn: rxActive, framingEnable: rxActive, // RQ13 RQ15
                      maskTimerRunning: timerRunning};
    assign regRdata = s.rdata;
    assign regRdValid = s.rdValid;
    assign cmdDone = s.done;
    assign cmdIgnored = s.ignored;
    assign opctlOut = s.opctl;
    assign typeAOut = s.typeA;
    assign auxOut = s.aux;
    assign rxCfg1Out = s.rxCfg1;
    assign rxCfg3Out = s.rxCfg3;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_rxchn;
        presetGo |=> s.opctl[OPC_RXCHN] == $past(nfcAct);
    endproperty
    a_rxchn: assert property (p_rxchn) // RQ3
        else $error("Preset channel count bit wrong.");

    property p_txen;
        presetGo && nfcAct |=> !s.opctl[OPC_TXEN] && !opctlOut[OPC_TXEN];
    endproperty
    a_txen: assert property (p_txen) // RQ4
        else $error("Preset left transmitter enabled in NFC mode.");

    property p_f0;
        presetGo |=>
            typeAOut[TA_START_AND_LENGTH_BYTE_INSERT] == $past(nfcAct);
    endproperty
    a_f0: assert property (p_f0) // RQ5
        else $error("Preset start byte insertion wrong.");

    property p_tram;
        presetGo && mode == MODE_ISO_A |=>
            !auxOut[AUX_TRANSMIT_MODULATION_TYPE];
    endproperty
    a_tram: assert property (p_tram) // RQ6
        else $error("Preset modulation type wrong for type A.");

    property p_fd;
        presetGo |=> auxOut[AUX_PEER_FIELD_DETECT_ENABLE] == $past(nfcAct);
    endproperty
    a_fd: assert property (p_fd) // RQ7
        else $error("Preset field detector enable wrong.");

    property p_amd;
        presetGo |=> rxCfg1Out[RX1_DEMOD_TYPE] == ($past(rxRate) > RATE_848);
    endproperty
    a_amd: assert property (p_amd) // RQ9
        else $error("Preset demodulator type wrong.");

    property p_clip;
        presetGo |=> rxCfg3Out[RX3_CLIP] == $past(nfcAct);
    endproperty
    a_clip: assert property (p_clip) // RQ11
        else $error("Preset clipping bit wrong.");

    property p_gain;
        presetGo |=> rxCfg3Out[RX3_FORCED_GAIN_REDUCTION] == $past(nfcAct);
    endproperty
    a_gain: assert property (p_gain) // RQ12
        else $error("Preset gain reduction bit wrong.");

    property p_mask;
        maskGo && rxEnBit |=> !rxCtrl.rxOn && !rxCtrl.framingEnable;
    endproperty
    a_mask: assert property (p_mask) // RQ13
        else $error("Receiver active after mask command.");

    property p_unmask;
        unmaskGo && rxEnBit && !regReq.we |=>
            rxCtrl.rxOn && !rxCtrl.maskTimerRunning;
    endproperty
    a_unmask: assert property (p_unmask) // RQ16
        else $error("Unmask did not enable reception.");

    property p_ignore;
        (maskGo || unmaskGo) && !rxEnBit |=>
            $stable(s.cmdMask) && cmdIgnored && !cmdDone;
    endproperty
    a_ignore: assert property (p_ignore) // RQ17
        else $error("Mask command taken with receiver disabled.");

    property p_keep;
        presetGo && !regReq.we |=>
            (opctlOut & 8'hD7) == ($past(opctlOut) & 8'hD7);
    endproperty
    a_keep: assert property (p_keep) // RQ19
        else $error("Preset changed an unlisted control bit.");

    property p_modam;
        presetGo && (mode == MODE_ISO_B || mode == MODE_CARD_212_424) |=>
            auxOut[AUX_TRANSMIT_MODULATION_TYPE];
    endproperty
    a_modam: assert property (p_modam) // RQ6
        else $error("Preset modulation type wrong for AM modes.");

    property p_modnfc;
        presetGo && nfcAct |=> auxOut[AUX_TRANSMIT_MODULATION_TYPE] ==
            ($past(txRate) != RATE_106);
    endproperty
    a_modnfc: assert property (p_modnfc) // RQ6
        else $error("Preset modulation type wrong for NFC modes.");

    property p_chsel;
        presetGo && nfcAct |=> !rxCfg1Out[RX1_DEMOD_CHANNEL_SELECT];
    endproperty
    a_chsel: assert property (p_chsel) // RQ8
        else $error("Preset did not select the AM channel.");

    property p_filter;
        presetGo && nfcAct |=> rxCfg1Out[RX1_FILTER_LSB +: 6] == FILT_NFC;
    endproperty
    a_filter: assert property (p_filter) // RQ10
        else $error("Preset filter field wrong for NFC modes.");

    property p_maskor;
        s.cmdMask || timerRunning |-> !rxCtrl.rxOn && !rxCtrl.framingEnable;
    endproperty
    a_maskor: assert property (p_maskor) // RQ14
        else $error("Reception active while a mask is set.");

    property p_unframe;
        unmaskGo && rxEnBit && !regReq.we |=> rxCtrl.framingEnable;
    endproperty
    a_unframe: assert property (p_unframe) // RQ15
        else $error("Unmask did not enable receive framing.");

    property p_chain;
        (maskGo || unmaskGo) && rxEnBit |=> cmdDone && !cmdIgnored;
    endproperty
    a_chain: assert property (p_chain) // RQ18
        else $error("Mask command not accepted with receiver enabled.");
endmodule : apr_core
`default_nettype wire

// ---- apr_pkg.sv ----
// Purpose: Shared constants and types for analog preset and receive masking.
// Assumes: One 40 MHz clock; register port already decoded from the serial port.
// Notes: Mode and bit rate codes are local encodings of this block.
`default_nettype none
package apr_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // Register addresses.
    localparam logic [5:0] ADDR_OPCTL = 6'h02;
    localparam logic [5:0] ADDR_MODE = 6'h03;
    localparam logic [5:0] ADDR_RATE = 6'h04;
    localparam logic [5:0] ADDR_TYPEA = 6'h05;
    localparam logic [5:0] ADDR_AUX = 6'h09;
    localparam logic [5:0] ADDR_RXCFG1 = 6'h0A;
    localparam logic [5:0] ADDR_RXCFG3 = 6'h0C;
    localparam logic [5:0] ADDR_MASK_PERIOD = 6'h10;
    // Reset values.
    localparam logic [7:0] RST_OPCTL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h00;
    localparam logic [7:0] RST_TYPEA = 8'h00;
    localparam logic [7:0] RST_AUX = 8'h00;
    localparam logic [7:0] RST_RXCFG1 = 8'h00;
    localparam logic [7:0] RST_RXCFG3 = 8'h00;
    localparam logic [7:0] RST_MASK_PERIOD = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // Field positions.
    localparam int OPC_EN = 7;
    localparam int OPC_RXEN = 6;
    localparam int OPC_RXCHN = 5;
    localparam int OPC_TXEN = 3;
    localparam int TA_START_AND_LENGTH_BYTE_INSERT = 5;
    localparam int AUX_TRANSMIT_MODULATION_TYPE = 5;
    localparam int AUX_PEER_FIELD_DETECT_ENABLE = 4;
    localparam int RX1_DEMOD_CHANNEL_SELECT = 7;
    localparam int RX1_DEMOD_TYPE = 6;
    localparam int RX1_FILTER_LSB = 0;
    localparam int RX3_CLIP = 1;
    localparam int RX3_FORCED_GAIN_REDUCTION = 0;
    localparam int MODE_LSB = 0;
    localparam int RATE_RX_LSB = 0;
    localparam int RATE_TX_LSB = 4;
    // Protocol modes held in the low nibble of the mode register.
    localparam logic [3:0] MODE_ISO_A = 4'h0;
    localparam logic [3:0] MODE_ISO_B = 4'h1;
    localparam logic [3:0] MODE_VICINITY = 4'h2;
    localparam logic [3:0] MODE_CARD_212_424 = 4'h3;
    localparam logic [3:0] MODE_NFC_INITIATOR = 4'h4;
    localparam logic [3:0] MODE_NFC_TARGET = 4'h5;
    localparam logic [3:0] MODE_SUBCARRIER_STREAM = 4'h6;
    localparam logic [3:0] MODE_BPSK_STREAM = 4'h7;
    // Bit rate codes; codes above RATE_848 exceed fc/16.
    localparam logic [3:0] RATE_106 = 4'h0;
    localparam logic [3:0] RATE_848 = 4'h3;
    // Low-pass and zero-setting field values (bits 5 to 0 of rx config one).
    localparam logic [5:0] FILT_NFC = 6'h08;
    localparam logic [5:0] FILT_LOW_RATE = 6'h00;
    localparam logic [5:0] FILT_HIGH_RATE = 6'h24;
    // Direct command codes.
    localparam logic [7:0] CMD_ANALOG_PRESET = 8'hCC;
    localparam logic [7:0] CMD_MASK_RX = 8'hD0;
    localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
    localparam logic [7:0] CMD_START_MASK_TIMER = 8'hE2;
    // Mask timer tick.
    localparam int unsigned MASK_TICK_NS = 1000;
    localparam int unsigned MASK_TICK_CYC =
        (MASK_TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] MASK_TICK_LAST = 8'(MASK_TICK_CYC - 1);

    typedef struct packed {
        logic we;
        logic re;
        logic [5:0] addr;
        logic [7:0] wdata;
    } apr_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } apr_cmd_t;

    typedef struct packed {
        logic rxOn;
        logic framingEnable;
        logic maskTimerRunning;
    } apr_rx_ctrl_t;

    typedef struct packed {
        logic [7:0] opctl;
        logic [7:0] modeDef;
        logic [7:0] rateDef;
        logic [7:0] typeA;
        logic [7:0] aux;
        logic [7:0] rxCfg1;
        logic [7:0] rxCfg3;
        logic [7:0] maskPeriod;
        logic cmdMask;
        logic [7:0] rdata;
        logic rdValid;
        logic done;
        logic ignored;
    } apr_core_state_t;

    typedef struct packed {
        logic [7:0] remain;
        logic [7:0] tick;
    } apr_tmr_state_t;

    function automatic logic isNfcActive(input logic [3:0] mode);
        return (mode == MODE_NFC_INITIATOR) || (mode == MODE_NFC_TARGET);
    endfunction : isNfcActive

    function automatic logic [5:0] filterFor(input logic [3:0] mode,
                                             input logic [3:0] rxRate);
        if (isNfcActive(mode)) begin
            return FILT_NFC;
        end
        return (rxRate > RATE_848) ? FILT_HIGH_RATE : FILT_LOW_RATE;
    endfunction : filterFor
endpackage : apr_pkg
`default_nettype wire

// ---- apr_mask_timer.sv ----
// Purpose: Mask receive timer that masks reception for a programmed time.
// Assumes: Period counts ticks of MASK_TICK_CYC clock cycles.
// Notes: Clear has priority over start.
`timescale 1ns/1ps
`default_nettype none
module apr_mask_timer (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Control.
    input wire logic start,
    input wire logic clear,
    input wire logic [7:0] period,
    // Status.
    output logic running
);
    import apr_pkg::*;

    apr_tmr_state_t s;
    apr_tmr_state_t next_s;

    always_comb begin
        next_s = s;
        if (clear) begin
            next_s.remain = 8'h00;
            next_s.tick = 8'h00;
        end else if (start) begin
            next_s.remain = period;
            next_s.tick = 8'h00;
        end else if (s.remain != 8'h00) begin
            if (s.tick == MASK_TICK_LAST) begin
                next_s.tick = 8'h00;
                next_s.remain = s.remain - 8'h01;
            end else begin
                next_s.tick = s.tick + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign running = (s.remain != 8'h00);
endmodule : apr_mask_timer
`default_nettype wire

// ---- apr_host_model.sv ----
// Purpose: Host model that issues register accesses and direct commands.
// Assumes: The core takes requests on the rising edge of clk_sys.
// Notes: Drives 1 ns after an edge; each request is a one-cycle pulse, except send2, which holds cmd valid for two cycles.
`timescale 1ns/1ps
`default_nettype none
module apr_host_model (
    // Clock.
    input wire logic clk_sys,
    // Register port.
    output var apr_pkg::apr_reg_req_t regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid,
    // Direct commands.
    output var apr_pkg::apr_cmd_t cmd
);
    import apr_pkg::*;

    initial begin
        regReq = '0;
        cmd = '0;
    end

    // Writes one register with a single strobe cycle.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        regReq = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        #1;
        regReq.we = 1'b0;
    endtask : wr

    // Reads one register; the answer is taken in the cycle after the strobe.
    task automatic rd(input logic [5:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge clk_sys);
        #1;
        regReq = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        #1;
        regReq.re = 1'b0;
        d = regRdata;
        v = regRdValid;
    endtask : rd

    // Sends one command; the preset is never sent in stream modes.
    task automatic send(input logic [7:0] c);
        @(posedge clk_sys);
        #1;
        cmd = '{valid: 1'b1, code: c};
        @(posedge clk_sys);
        #1;
        cmd.valid = 1'b0;
    endtask : send

    // Sends two commands on consecutive cycles.
    task automatic send2(input logic [7:0] c0, input logic [7:0] c1);
        @(posedge clk_sys);
        #1;
        cmd = '{valid: 1'b1, code: c0};
        @(posedge clk_sys);
        #1;
        cmd.code = c1;
        @(posedge clk_sys);
        #1;
        cmd.valid = 1'b0;
    endtask : send2
endmodule : apr_host_model
`default_nettype wire

// ---- tb_analog_preset_and_rx_mask.sv ----
// Purpose: Self-checking bench for analog preset and receive masking.
// Assumes: 40 MHz clock; mask timer unit of 40 cycles.
// Notes: Expected values are derived here from mode and rate.
`timescale 1ns/1ps
`default_nettype none
module tb_analog_preset_and_rx_mask;
    import apr_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    apr_reg_req_t regReq;
    apr_cmd_t cmd;
    apr_rx_ctrl_t rxCtrl;
    logic [7:0] regRdata, opctlOut, typeAOut, auxOut, rxCfg1Out, rxCfg3Out;
    logic regRdValid, cmdDone, cmdIgnored;
    int errCount = 0;
    int samplesChecked = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    apr_core DUT (.clk_sys(clk_sys), .arst_n(arst_n), .regReq(regReq),
        .regRdata(regRdata), .regRdValid(regRdValid), .cmd(cmd),
        .cmdDone(cmdDone), .cmdIgnored(cmdIgnored), .rxCtrl(rxCtrl),
        .opctlOut(opctlOut), .typeAOut(typeAOut), .auxOut(auxOut),
        .rxCfg1Out(rxCfg1Out), .rxCfg3Out(rxCfg3Out));
    apr_host_model host (.clk_sys(clk_sys), .regReq(regReq),
        .regRdata(regRdata), .regRdValid(regRdValid), .cmd(cmd));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkb(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkb

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errCount++;
            summarize();
        end
    end

    task automatic testReset;
        logic [5:0] a [9];
        logic [7:0] d;
        logic v;
        a = '{ADDR_OPCTL, ADDR_MODE, ADDR_RATE, ADDR_TYPEA, ADDR_AUX,
              ADDR_RXCFG1, ADDR_RXCFG3, ADDR_MASK_PERIOD, 6'h3F};
        chkb(rxCtrl.rxOn, 1'b0);
        host.wr(6'h3F, 8'hFF);
        foreach (a[i]) begin
            host.rd(a[i], d, v);
            chkb(v, 1'b1);
            chk8(d, 8'h00);
        end
        $display("test reset done");
    endtask : testReset

    task automatic testPreset;
        logic [7:0] rates [3];
        logic [7:0] pre, e, d;
        logic nfc, hi, v;
        rates = '{8'h00, 8'h03, 8'h34};
        for (int p = 0; p < 2; p++) begin
            pre = (p == 0) ? 8'h00 : 8'hFF;
            for (int m = 0; m < 6; m++) begin
                foreach (rates[r]) begin
                    host.wr(ADDR_OPCTL, pre);
                    host.wr(ADDR_MODE, 8'(m));
                    host.wr(ADDR_RATE, rates[r]);
                    host.wr(ADDR_TYPEA, pre);
                    host.wr(ADDR_AUX, pre);
                    host.wr(ADDR_RXCFG1, pre);
                    host.wr(ADDR_RXCFG3, pre);
                    host.send(CMD_ANALOG_PRESET);
                    chkb(cmdDone, 1'b1);
                    nfc = (m == 4) || (m == 5);
                    hi = rates[r][3:0] > 4'h3;
                    e = nfc ? ((pre | 8'h20) & 8'hF7) : (pre & 8'hDF);
                    chk8(opctlOut, e);
                    chk8(typeAOut & 8'hDF, pre & 8'hDF);
                    if (nfc) begin
                        chkb(typeAOut[5], 1'b1);
                    end
                    e = pre;
                    e[4] = nfc;
                    case (m)
                        0: e[5] = 1'b0;
                        1, 3: e[5] = 1'b1;
                        4, 5: e[5] = rates[r][7:4] != 4'h0;
                        default: e[5] = pre[5];
                    endcase
                    chk8(auxOut, e);
                    chk8(rxCfg3Out, {pre[7:2], nfc, nfc});
                    e = {nfc ? 1'b0 : pre[7], hi, nfc ? FILT_NFC :
                         (hi ? FILT_HIGH_RATE : FILT_LOW_RATE)};
                    host.rd(ADDR_RXCFG1, d, v);
                    chk8(d, e);
                end
            end
        end
        $display("test preset done");
    endtask : testPreset

    task automatic testMaskCmds;
        host.wr(ADDR_OPCTL, 8'h00);
        host.send(CMD_MASK_RX);
        chkb(cmdIgnored, 1'b1);
        host.wr(ADDR_OPCTL, 8'h40);
        host.send(CMD_UNMASK_RX);
        chkb(cmdDone, 1'b1);
        chkb(rxCtrl.rxOn, 1'b1);
        chkb(rxCtrl.framingEnable, 1'b1);
        host.send2(CMD_UNMASK_RX, CMD_MASK_RX);
        chkb(cmdDone, 1'b1);
        chkb(rxCtrl.rxOn, 1'b0);
        chkb(rxCtrl.framingEnable, 1'b0);
        host.wr(ADDR_OPCTL, 8'h00);
        host.send(CMD_UNMASK_RX);
        chkb(cmdIgnored, 1'b1);
        host.wr(ADDR_OPCTL, 8'h40);
        chkb(rxCtrl.rxOn, 1'b0);
        host.send2(CMD_MASK_RX, CMD_UNMASK_RX);
        chkb(rxCtrl.rxOn, 1'b1);
        $display("test mask commands done");
    endtask : testMaskCmds

    task automatic waitTimer;
        for (int i = 0; i < 20 && rxCtrl.maskTimerRunning !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chkb(rxCtrl.maskTimerRunning, 1'b0);
    endtask : waitTimer

    task automatic testMaskTimer;
        host.wr(ADDR_MASK_PERIOD, 8'h02);
        host.send(CMD_START_MASK_TIMER);
        chkb(rxCtrl.maskTimerRunning, 1'b1);
        chkb(rxCtrl.rxOn, 1'b0);
        repeat (70) @(posedge clk_sys);
        #1;
        chkb(rxCtrl.maskTimerRunning, 1'b1);
        waitTimer();
        chkb(rxCtrl.rxOn, 1'b1);
        host.send(CMD_MASK_RX);
        host.send(CMD_START_MASK_TIMER);
        repeat (70) @(posedge clk_sys);
        #1;
        waitTimer();
        chkb(rxCtrl.rxOn, 1'b0);
        host.send(CMD_UNMASK_RX);
        host.send(CMD_START_MASK_TIMER);
        repeat (10) @(posedge clk_sys);
        host.send(CMD_UNMASK_RX);
        chkb(rxCtrl.maskTimerRunning, 1'b0);
        chkb(rxCtrl.rxOn, 1'b1);
        repeat (100) @(posedge clk_sys);
        #1;
        chkb(rxCtrl.rxOn, 1'b1);
        $display("test mask timer done");
    endtask : testMaskTimer

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        testReset();
        testPreset();
        testMaskCmds();
        testMaskTimer();
        summarize();
    end
endmodule : tb_analog_preset_and_rx_mask
`default_nettype wire
